// *** rtl/rss_consts.svh ***
// Ramp/soak sequencer constants: offsets, fields, resets, time counts.
// Definitions only.
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// Register offsets (word index)
`define RSS_A_CMD       5'h00
`define RSS_A_MODE      5'h01
`define RSS_A_GSOK      5'h02
`define RSS_A_BAND_UP   5'h03
`define RSS_A_BAND_LO   5'h04
`define RSS_A_MEASURED_START_ENABLE      5'h05
`define RSS_A_POLICY    5'h06
`define RSS_A_CEIL      5'h07
`define RSS_A_FLOOR     5'h08
`define RSS_A_FIRST     5'h09
`define RSS_A_LAST      5'h0A
`define RSS_A_TBL_IDX   5'h0B
`define RSS_A_TBL_SP    5'h0C
`define RSS_A_TBL_RAMP  5'h0D
`define RSS_A_TBL_SOAK  5'h0E
`define RSS_A_STATUS    5'h0F
`define RSS_A_SETPOINT  5'h10
`define RSS_A_PATSEL    5'h11

// Option code bit positions
`define RSS_MODE_PON    3
`define RSS_MODE_ENDH   2
`define RSS_MODE_OFFO   1
`define RSS_MODE_REP    0

// Limits and reset values
`define RSS_HALF_FS     16'h7FFF
`define RSS_EXT_PAT     5'h1F
`define RSS_RST_FIRST   6'h00
`define RSS_RST_LAST    6'h03

// Continue-policy snapshot age: minutes, then time-base ticks
`define RSS_SNAP_MIN     5
`define RSS_TICK_PER_MIN 60
`define RSS_SNAP_TICKS   (`RSS_SNAP_MIN * `RSS_TICK_PER_MIN)

`endif

// *** rtl/rss_pkg.sv ***
// Types of the ramp/soak option sequencer.
// Assumes rss_consts.svh holds the numeric constants.
package rss_pkg;
  typedef enum logic [1:0] {st_stop, st_ramp, st_soak, st_end} rss_state_t;
  typedef enum logic [1:0] {cmd_stop, cmd_run, cmd_hold} rss_cmd_t;
  typedef enum logic [1:0] {resume_none, resume_continue, resume_initial} rss_policy_t;
endpackage

// *** rtl/rss_band_check.sv ***
// Guaranteed-soak band check.
// Assumes the caller limits both widths to half scale.
`timescale 1ns/100ps
module rss_band_check (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] step_sp,
  input  wire logic [15:0] measured_value,
  input  wire logic [15:0] soak_band_upper,
  input  wire logic [15:0] soak_band_lower,
  output logic             in_band
);
  logic [16:0] band_hi;
  logic [16:0] band_lo;
  logic [16:0] pv_ext;

  // Widened so the band may reach past either end of the scale
  assign band_hi = {1'b0, step_sp} + {1'b0, soak_band_upper};
  assign band_lo = {1'b0, step_sp} - {1'b0, soak_band_lower};
  assign pv_ext  = {1'b0, measured_value};

  // Registered; one cycle of lag is negligible against the time base
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      in_band <= 1'b0;
    else
      in_band <= (pv_ext <= band_hi) &&
                 (band_lo[16] || pv_ext >= band_lo);
  end
endmodule

// *** rtl/rss_sequencer.sv ***
// Ramp/soak program sequencer: option code, guaranteed soak, measured start,
// power-resume policy and function-key pattern stepping.
// Assumes synchronous inputs; time_tick, power_on and power_return
// are one-clock pulses.
// Behaviour
// - Command stop halts, run starts, hold freezes until run again.
// - Option code bits: power-on start, end standby, off standby, repeat.
// - Power-on start begins the program from the measured value.
// - Final state is kept at completion whether or not the end option is set, unless repeat or off is on.
// - Off option drops the sequencer to stopped at completion.
// - Repeat restarts at the first step after the last one.
// - Guaranteed soak counts down only while measured value is in band.
// - Band has upper and lower widths, each up to half scale.
// - Next step when accumulated in-band time equals soak time.
// - Band check uses the programmed step setpoint, not a clipped one.
// - Measured start searches the program on each run command from stop or end.
// - Measured value equal to a setpoint enters that soak.
// - Value inside a ramp span enters that ramp midway.
// - Value below all setpoints ramps from it to the first target.
// - Value above all or over range soaks at the highest setpoint.
// - Value under range soaks at the lowest setpoint.
// - Measured start is ignored under the continue policy.
// - Reset policy leaves the program stopped after power returns.
// - Continue policy resumes from a snapshot at most 5 minutes old.
// - Initial policy restarts from the first step after power returns.
// - Pattern ceiling and floor 0 to 30 or external bound key stepping.
// - External selection comes after pattern 30 in key stepping.
`timescale 1ns/100ps
`include "rss_consts.svh"
module rss_sequencer #(
  parameter int NSTEP      = 64,
  parameter int SNAP_TICKS = `RSS_SNAP_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        time_tick,
  input  wire logic        power_on,
  input  wire logic        power_return,
  input  wire logic [15:0] measured_value,
  input  wire logic        over_range,
  input  wire logic        under_range,
  input  wire logic        key_up,
  input  wire logic        key_down,
  output logic      [15:0] target_setpoint,
  output logic      [1:0]  seq_state,
  output logic             seq_holding,
  output logic             out_of_band,
  output logic      [5:0]  step_index,
  output logic      [4:0]  pattern_select,
  output logic             external_input_pattern_select
);
  localparam int SW = $clog2(NSTEP);

  // Configuration
  logic [3:0]  mode;
  logic        gsok;
  logic [15:0] soak_band_upper;
  logic [15:0] soak_band_lower;
  logic        measured_start_enable;
  rss_pkg::rss_policy_t power_resume_policy;
  logic [4:0]  pattern_ceiling;
  logic [4:0]  pattern_floor;
  logic [SW-1:0] first;
  logic [SW-1:0] last;
  logic [SW-1:0] tbl_idx;
  logic [15:0] step_setpoints [NSTEP];
  logic [15:0] ramp_tbl [NSTEP];
  logic [15:0] soak_tbl [NSTEP];

  // Sequencer state
  rss_pkg::rss_state_t state;
  rss_pkg::rss_cmd_t   program_command;
  logic          held;
  logic [SW-1:0] step;
  logic [15:0]   ramp_rem;
  logic [15:0]   soak_rem;
  logic          in_band;

  // Snapshot for the continue policy
  rss_pkg::rss_state_t snap_state;
  rss_pkg::rss_cmd_t   snap_cmd;
  logic          snap_held;
  logic [SW-1:0] snap_step;
  logic [15:0]   snap_sp;
  logic [15:0]   snap_ramp;
  logic [15:0]   snap_soak;
  logic [31:0]   snap_cnt;

  logic wr_cmd;
  logic [16:0] delta;
  logic [16:0] ramp_inc;

  assign wr_cmd = reg_write && reg_addr == `RSS_A_CMD;

  // Configuration writes; band widths clip at half scale
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode                  <= 4'h0;
      gsok                  <= 1'b0;
      soak_band_upper       <= 16'h0000;
      soak_band_lower       <= 16'h0000;
      measured_start_enable <= 1'b0;
      power_resume_policy   <= rss_pkg::resume_none;
      pattern_ceiling       <= 5'h00;
      pattern_floor         <= 5'h00;
      first                 <= SW'(`RSS_RST_FIRST);
      last                  <= SW'(`RSS_RST_LAST);
      tbl_idx               <= '0;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `RSS_A_MODE:    mode <= reg_wdata[3:0];
        `RSS_A_GSOK:    gsok <= reg_wdata[0];
        `RSS_A_BAND_UP: soak_band_upper <= (reg_wdata > `RSS_HALF_FS) ?
                                           `RSS_HALF_FS : reg_wdata;
        `RSS_A_BAND_LO: soak_band_lower <= (reg_wdata > `RSS_HALF_FS) ?
                                           `RSS_HALF_FS : reg_wdata;
        `RSS_A_MEASURED_START_ENABLE:    measured_start_enable <= reg_wdata[0];
        `RSS_A_POLICY:
          // A policy change mid-program is refused, not deferred
          if (program_command == rss_pkg::cmd_stop && reg_wdata[1:0] != 2'h3)
            power_resume_policy <= rss_pkg::rss_policy_t'(reg_wdata[1:0]);
        `RSS_A_CEIL:    pattern_ceiling <= reg_wdata[4:0];
        `RSS_A_FLOOR:   pattern_floor <= reg_wdata[4:0];
        `RSS_A_FIRST:   first <= reg_wdata[SW-1:0];
        `RSS_A_LAST:    last <= reg_wdata[SW-1:0];
        `RSS_A_TBL_IDX: tbl_idx <= reg_wdata[SW-1:0];
        default:        ;
      endcase
    end
  end

  // Step table, written through the index register
  always_ff @(posedge clk_sys)
  begin
    if (reg_write && reg_addr == `RSS_A_TBL_SP)
      step_setpoints[tbl_idx] <= reg_wdata;
    if (reg_write && reg_addr == `RSS_A_TBL_RAMP)
      ramp_tbl[tbl_idx] <= reg_wdata;
    if (reg_write && reg_addr == `RSS_A_TBL_SOAK)
      soak_tbl[tbl_idx] <= reg_wdata;
  end

  // Band check against the programmed setpoint of the current step
  rss_band_check u_band (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .step_sp         (step_setpoints[step]),
    .measured_value  (measured_value),
    .soak_band_upper (soak_band_upper),
    .soak_band_lower (soak_band_lower),
    .in_band         (in_band)
  );

  // Measured-start search over the active steps
  logic [SW-1:0] lo_idx;
  logic [SW-1:0] hi_idx;
  logic [SW-1:0] hit_idx;
  logic          hit;
  logic          hit_ramp;
  logic [SW-1:0] srch_step;
  rss_pkg::rss_state_t srch_state;
  logic [15:0]   srch_ramp;
  logic [15:0]   span;
  logic [15:0]   part;
  logic [31:0]   prod;

  always_comb
  begin
    lo_idx   = first;
    hi_idx   = first;
    hit_idx  = first;
    hit      = 1'b0;
    hit_ramp = 1'b0;
    for (int i = 0; i < NSTEP; i++)
    begin
      if (SW'(i) >= first && SW'(i) <= last)
      begin
        if (step_setpoints[i] > step_setpoints[hi_idx])
          hi_idx = SW'(i);
        if (step_setpoints[i] < step_setpoints[lo_idx])
          lo_idx = SW'(i);
        if (!hit && measured_value == step_setpoints[i])
        begin
          hit     = 1'b1;
          hit_idx = SW'(i);
        end
        else if (!hit && SW'(i) > first &&
                 ((measured_value > step_setpoints[SW'(i - 1)] &&
                   measured_value < step_setpoints[i]) ||
                  (measured_value < step_setpoints[SW'(i - 1)] &&
                   measured_value > step_setpoints[i])))
        begin
          hit      = 1'b1;
          hit_ramp = 1'b1;
          hit_idx  = SW'(i);
        end
      end
    end
  end

  // Ramp time left scales with the distance left
  always_comb
  begin
    span = (step_setpoints[hit_idx] > step_setpoints[SW'(hit_idx - 1'b1)]) ?
           step_setpoints[hit_idx] - step_setpoints[SW'(hit_idx - 1'b1)] :
           step_setpoints[SW'(hit_idx - 1'b1)] - step_setpoints[hit_idx];
    part = (step_setpoints[hit_idx] > measured_value) ?
           step_setpoints[hit_idx] - measured_value :
           measured_value - step_setpoints[hit_idx];
    prod = ramp_tbl[hit_idx] * part;
    srch_step  = first;
    srch_state = rss_pkg::st_ramp;
    srch_ramp  = ramp_tbl[first];
    if (under_range)
    begin
      srch_step  = lo_idx;
      srch_state = rss_pkg::st_soak;
    end
    else if (over_range ||
             (!hit && measured_value > step_setpoints[hi_idx]))
    begin
      srch_step  = hi_idx;
      srch_state = rss_pkg::st_soak;
    end
    else if (hit && !hit_ramp)
    begin
      srch_step  = hit_idx;
      srch_state = rss_pkg::st_soak;
    end
    else if (hit)
    begin
      srch_step = hit_idx;
      srch_ramp = (span == 16'h0000) ? 16'h0000 : 16'((prod / span));
    end
    // Otherwise below every setpoint: ramp from the value to the first target
  end

  // Linear ramp: spread what is left over the ticks left
  assign delta    = {1'b0, step_setpoints[step]} - {1'b0, target_setpoint};
  assign ramp_inc = (ramp_rem == 16'h0000) ? 17'h0_0000 :
                    17'($signed(delta) / $signed({1'b0, ramp_rem}));

  // Program sequencing: commands, power events, ramp and soak timing
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state           <= rss_pkg::st_stop;
      program_command <= rss_pkg::cmd_stop;
      held            <= 1'b0;
      step            <= '0;
      target_setpoint <= 16'h0000;
      ramp_rem        <= 16'h0000;
      soak_rem        <= 16'h0000;
    end
    else if (power_return && power_resume_policy == rss_pkg::resume_none)
    begin
      state           <= rss_pkg::st_stop;
      program_command <= rss_pkg::cmd_stop;
      held            <= 1'b0;
    end
    else if (power_return && power_resume_policy == rss_pkg::resume_continue)
    begin
      state           <= snap_state;
      program_command <= snap_cmd;
      held            <= snap_held;
      step            <= snap_step;
      target_setpoint <= snap_sp;
      ramp_rem        <= snap_ramp;
      soak_rem        <= snap_soak;
    end
    // Initial policy and power-on start both ramp from the measured value
    else if (power_return || (power_on && mode[`RSS_MODE_PON]))
    begin
      state           <= rss_pkg::st_ramp;
      program_command <= rss_pkg::cmd_run;
      held            <= 1'b0;
      step            <= first;
      target_setpoint <= measured_value;
      ramp_rem        <= ramp_tbl[first];
    end
    else if (wr_cmd && reg_wdata[1:0] == 2'h0)
    begin
      state           <= rss_pkg::st_stop;
      program_command <= rss_pkg::cmd_stop;
      held            <= 1'b0;
    end
    else if (wr_cmd && reg_wdata[1:0] == 2'h1)
    begin
      program_command <= rss_pkg::cmd_run;
      held            <= 1'b0;
      if (state == rss_pkg::st_stop || state == rss_pkg::st_end)
      begin
        target_setpoint <= measured_value;
        if (measured_start_enable &&
            power_resume_policy != rss_pkg::resume_continue)
        begin
          state    <= srch_state;
          step     <= srch_step;
          ramp_rem <= srch_ramp;
          soak_rem <= soak_tbl[srch_step];
          if (srch_state == rss_pkg::st_soak)
            target_setpoint <= step_setpoints[srch_step];
        end
        else
        begin
          state    <= rss_pkg::st_ramp;
          step     <= first;
          ramp_rem <= ramp_tbl[first];
        end
      end
    end
    else if (wr_cmd && reg_wdata[1:0] == 2'h2 && state != rss_pkg::st_stop)
    begin
      program_command <= rss_pkg::cmd_hold;
      held            <= 1'b1;
    end
    else if (!held && state == rss_pkg::st_ramp)
    begin
      if (ramp_rem == 16'h0000)
      begin
        // Zero ramp time is skipped straight into the soak
        state           <= rss_pkg::st_soak;
        target_setpoint <= step_setpoints[step];
        soak_rem        <= soak_tbl[step];
      end
      else if (time_tick)
      begin
        ramp_rem        <= ramp_rem - 16'h0001;
        target_setpoint <= (ramp_rem == 16'h0001) ? step_setpoints[step] :
                           target_setpoint + ramp_inc[15:0];
      end
    end
    else if (!held && state == rss_pkg::st_soak)
    begin
      if (soak_rem == 16'h0000)
      begin
        if (step != last)
        begin
          step     <= step + 1'b1;
          state    <= rss_pkg::st_ramp;
          ramp_rem <= ramp_tbl[SW'(step + 1'b1)];
        end
        else if (mode[`RSS_MODE_REP])
        begin
          step     <= first;
          state    <= rss_pkg::st_ramp;
          ramp_rem <= ramp_tbl[first];
        end
        else if (mode[`RSS_MODE_OFFO])
        begin
          state           <= rss_pkg::st_stop;
          program_command <= rss_pkg::cmd_stop;
        end
        else
          state <= rss_pkg::st_end;
      end
      else if (time_tick && (!gsok || in_band))
        soak_rem <= soak_rem - 16'h0001;
    end
  end

  // Periodic snapshot; a restore is at most one interval old
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      snap_cnt   <= 32'h0000_0000;
      snap_state <= rss_pkg::st_stop;
      snap_cmd   <= rss_pkg::cmd_stop;
      snap_held  <= 1'b0;
      snap_step  <= '0;
      snap_sp    <= 16'h0000;
      snap_ramp  <= 16'h0000;
      snap_soak  <= 16'h0000;
    end
    else if (time_tick)
    begin
      if (snap_cnt >= 32'(SNAP_TICKS - 1))
      begin
        snap_cnt   <= 32'h0000_0000;
        snap_state <= state;
        snap_cmd   <= program_command;
        snap_held  <= held;
        snap_step  <= step;
        snap_sp    <= target_setpoint;
        snap_ramp  <= ramp_rem;
        snap_soak  <= soak_rem;
      end
      else
        snap_cnt <= snap_cnt + 32'h0000_0001;
    end
  end

  // Key stepping between floor and ceiling, only while stopped
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pattern_select <= 5'h00;
    else if (state == rss_pkg::st_stop)
    begin
      // Code 31 is the external selection, so it follows 30 naturally
      if (key_up && pattern_select < pattern_ceiling)
        pattern_select <= pattern_select + 5'h01;
      else if (key_down && pattern_select > pattern_floor)
        pattern_select <= pattern_select - 5'h01;
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_read)
    begin
      unique case (reg_addr)
        `RSS_A_CMD:      reg_rdata <= {14'h0000, program_command};
        `RSS_A_MODE:     reg_rdata <= {12'h000, mode};
        `RSS_A_GSOK:     reg_rdata <= {15'h0000, gsok};
        `RSS_A_BAND_UP:  reg_rdata <= soak_band_upper;
        `RSS_A_BAND_LO:  reg_rdata <= soak_band_lower;
        `RSS_A_MEASURED_START_ENABLE:     reg_rdata <= {15'h0000, measured_start_enable};
        `RSS_A_POLICY:   reg_rdata <= {14'h0000, power_resume_policy};
        `RSS_A_CEIL:     reg_rdata <= {11'h000, pattern_ceiling};
        `RSS_A_FLOOR:    reg_rdata <= {11'h000, pattern_floor};
        `RSS_A_FIRST:    reg_rdata <= 16'(first);
        `RSS_A_LAST:     reg_rdata <= 16'(last);
        `RSS_A_TBL_IDX:  reg_rdata <= 16'(tbl_idx);
        `RSS_A_TBL_SP:   reg_rdata <= step_setpoints[tbl_idx];
        `RSS_A_TBL_RAMP: reg_rdata <= ramp_tbl[tbl_idx];
        `RSS_A_TBL_SOAK: reg_rdata <= soak_tbl[tbl_idx];
        `RSS_A_STATUS:   reg_rdata <= {2'h0, step_index, 4'h0, out_of_band,
                                       held, state};
        `RSS_A_SETPOINT: reg_rdata <= target_setpoint;
        `RSS_A_PATSEL:   reg_rdata <= {11'h000, pattern_select};
        default:         reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Status outputs
  assign seq_state   = state;
  assign seq_holding = held;
  assign step_index  = 6'(step);
  assign out_of_band = gsok && state == rss_pkg::st_soak && !in_band;
  assign external_input_pattern_select = (pattern_select == `RSS_EXT_PAT);
endmodule

// *** verification/rss_seq_asserts.sv ***
// Port-level checks for the ramp/soak option sequencer.
// Bound from the bench top; key limits shadowed from writes.
`timescale 1ns/100ps
`include "rss_consts.svh"
module rss_seq_asserts (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        power_on,
  input wire logic        power_return,
  input wire logic [15:0] measured_value,
  input wire logic        key_up,
  input wire logic        key_down,
  input wire logic [15:0] target_setpoint,
  input wire logic [1:0]  seq_state,
  input wire logic        seq_holding,
  input wire logic        out_of_band,
  input wire logic [5:0]  step_index,
  input wire logic [4:0]  pattern_select,
  input wire logic        external_input_pattern_select
);
  logic [4:0] ceil_q;
  logic [4:0] floor_q;
  logic       cmd_wr;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Command writes not overruled by a power event
  assign cmd_wr = reg_write && reg_addr == `RSS_A_CMD && !power_on && !power_return;
  // Shadow of the key stepping limits
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ceil_q  <= 5'h00;
      floor_q <= 5'h00;
    end
    else if (reg_write)
    begin
      if (reg_addr == `RSS_A_CEIL)
        ceil_q <= reg_wdata[4:0];
      if (reg_addr == `RSS_A_FLOOR)
        floor_q <= reg_wdata[4:0];
    end
  end
  a_ext_after_top: assert property (
    external_input_pattern_select == (pattern_select == `RSS_EXT_PAT))
    else $error("external flag disagrees with pattern");
  a_key_up_step: assert property (
    (seq_state == 2'd0 && key_up && !reg_write && pattern_select < ceil_q)
    |=> pattern_select == $past(pattern_select) + 5'h01)
    else $error("key up did not step once");
  a_key_down_step: assert property (
    (seq_state == 2'd0 && key_down && !key_up && !reg_write && pattern_select > floor_q)
    |=> pattern_select == $past(pattern_select) - 5'h01)
    else $error("key down did not step once");
  a_key_run_lock: assert property (
    (seq_state != 2'd0 && !reg_write) |=> $stable(pattern_select))
    else $error("pattern moved while running");
  a_stop_cmd_halts: assert property (
    (cmd_wr && reg_wdata == 16'h0000) |=> seq_state == 2'd0)
    else $error("stop command did not halt");
  a_run_cmd_starts: assert property (
    (cmd_wr && reg_wdata == 16'h0001 && seq_state == 2'd0) |=> seq_state != 2'd0)
    else $error("run command did not start");
  a_ramp_from_pv: assert property (
    (cmd_wr && reg_wdata == 16'h0001 && seq_state == 2'd0)
    |=> (seq_state != 2'd1 || target_setpoint == $past(measured_value)))
    else $error("ramp entry not at measured value");
  a_hold_freezes: assert property (
    (seq_holding && !reg_write && !power_on && !power_return)
    |=> $stable(target_setpoint) && $stable(step_index) && $stable(seq_state))
    else $error("sequence moved while held");
  a_oob_in_soak: assert property (
    out_of_band |-> seq_state == 2'd2)
    else $error("out of band flagged outside soak");
  a_end_stays: assert property (
    (seq_state == 2'd3 && !reg_write && !power_on && !power_return) |=> seq_state == 2'd3)
    else $error("end state not kept");
endmodule

// *** verification/tb.sv ***
// Self-checking bench of the ramp/soak sequencer.
// Assumes the rss_consts.svh register map and a 125 MHz clock.
`timescale 1ns/100ps
`include "rss_consts.svh"
module tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        time_tick = 1'b0;
  logic        power_on = 1'b0;
  logic        power_return = 1'b0;
  logic [15:0] measured_value = 16'h0800;
  logic        over_range = 1'b0;
  logic        under_range = 1'b0;
  logic        key_up = 1'b0;
  logic        key_down = 1'b0;
  logic [15:0] target_setpoint;
  logic [1:0]  seq_state;
  logic        seq_holding;
  logic        out_of_band;
  logic [5:0]  step_index;
  logic [4:0]  pattern_select;
  logic        external_input_pattern_select;
  logic [15:0] exp_q[$];
  logic [4:0]  adr_q[$];
  logic        rd_d = 1'b0;
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 75;
  logic [15:0] mode_tab[5] = '{16'h0000, 16'h0004, 16'h0002, 16'h0006, 16'h0005};
  logic [1:0]  st_tab[5] = '{2'd3, 2'd3, 2'd0, 2'd0, 2'd1};
  logic [5:0]  sx_tab[5] = '{6'h01, 6'h01, 6'h3F, 6'h3F, 6'h00};
  logic [15:0] pv_tab[5] = '{16'h2000, 16'h1800, 16'h5000, 16'h0000, 16'h0000};
  logic [1:0]  rg_tab[5] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01};
  logic [15:0] ss_tab[5] = '{16'h0102, 16'h0101, 16'h0102, 16'h0102, 16'h0002};
  // Short snapshot interval and small table keep the run brief
  rss_sequencer #(.NSTEP(8), .SNAP_TICKS(4)) dut (.*);
  always #4 clk_sys = ~clk_sys;
  // Read data is checked in the cycle after the strobe; it holds until the next read
  always @(posedge clk_sys)
  begin
    rd_d <= reg_read;
    if (rd_d)
      chk(adr_q.pop_front(), exp_q.pop_front(), reg_rdata);
  end
  task automatic chk(input logic [4:0] a, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected reg %h: expected %h seen %h", a, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    adr_q.push_back(a);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask
  task automatic cmd(input logic [15:0] c);
    wr(`RSS_A_CMD, c);
  endtask
  // Time base runs while waiting; a hang counts as a mismatch
  task automatic wait_st(input logic [1:0] s, input logic [5:0] sx);
    int i;
    for (i = 0; i < 400 && !(seq_state === s && (sx == 6'h3F || step_index === sx)); i++)
    begin
      time_tick <= (i % 4 == 1);
      @(posedge clk_sys);
    end
    time_tick <= 1'b0;
    tests_run++;
    if (i == 400)
    begin
      fail_count++;
      $display("unexpected state: expected %h/%h seen %h/%h", s, sx, seq_state, step_index);
    end
  endtask
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      time_tick <= 1'b1;
      @(posedge clk_sys);
      time_tick <= 1'b0;
    end
  endtask
  task automatic pw(input bit ret);
    @(posedge clk_sys);
    {power_return, power_on} <= {ret, !ret};
    @(posedge clk_sys);
    {power_return, power_on} <= 2'b00;
  endtask
  task automatic key(input bit up, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      {key_up, key_down} <= {up, !up};
      @(posedge clk_sys);
      {key_up, key_down} <= 2'b00;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Tests: defaults, modes, hold, soak band, start search, power, keys
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`RSS_A_MODE, 16'h0000);
    rd(`RSS_A_POLICY, 16'h0000);
    rd(`RSS_A_LAST, 16'h0003);
    rd(5'h1F, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      wr(`RSS_A_TBL_IDX, 16'(k));
      wr(`RSS_A_TBL_SP, 16'h1000 * 16'(k + 1));
      wr(`RSS_A_TBL_RAMP, 16'h0008);
      wr(`RSS_A_TBL_SOAK, 16'h0004);
    end
    wr(`RSS_A_LAST, 16'h0001);
    wr(`RSS_A_BAND_UP, 16'hFFFF);
    rd(`RSS_A_BAND_UP, 16'h7FFF);
    wr(`RSS_A_BAND_UP, 16'h0100);
    wr(`RSS_A_BAND_LO, 16'h0100);
    $display("test defaults done");
    foreach (mode_tab[k])
    begin
      cmd(16'h0000);
      wr(`RSS_A_MODE, mode_tab[k]);
      cmd(16'h0001);
      wait_st(2'd1, 6'h01);
      wait_st(st_tab[k], sx_tab[k]);
    end
    $display("test modes done");
    cmd(16'h0000);
    wr(`RSS_A_MODE, 16'h0000);
    cmd(16'h0001);
    cmd(16'h0002);
    tk(3);
    rd(`RSS_A_STATUS, 16'h0005);
    rd(`RSS_A_SETPOINT, 16'h0800);
    cmd(16'h0001);
    rd(`RSS_A_STATUS, 16'h0001);
    $display("test hold done");
    wr(`RSS_A_GSOK, 16'h0001);
    wait_st(2'd2, 6'h00);
    tk(6);
    rd(`RSS_A_STATUS, 16'h000A);
    measured_value <= 16'h10C0;
    wait_st(2'd2, 6'h01);
    wr(`RSS_A_GSOK, 16'h0000);
    $display("test soak done");
    wr(`RSS_A_MEASURED_START_ENABLE, 16'h0001);
    foreach (pv_tab[k])
    begin
      measured_value <= pv_tab[k];
      {over_range, under_range} <= rg_tab[k];
      cmd(16'h0000);
      cmd(16'h0001);
      rd(`RSS_A_STATUS, ss_tab[k]);
    end
    {over_range, under_range} <= 2'b00;
    rd(`RSS_A_SETPOINT, 16'h1000);
    repeat (3)
    begin
      measured_value <= 16'($random(seed)) & 16'h0FFF;
      cmd(16'h0000);
      cmd(16'h0001);
      rd(`RSS_A_STATUS, 16'h0001);
      rd(`RSS_A_SETPOINT, measured_value);
    end
    $display("test start done");
    pw(1'b1);
    wait_st(2'd0, 6'h3F);
    wr(`RSS_A_POLICY, 16'h0002);
    cmd(16'h0001);
    wait_st(2'd2, 6'h01);
    wr(`RSS_A_POLICY, 16'h0001);
    rd(`RSS_A_POLICY, 16'h0002);
    pw(1'b1);
    rd(`RSS_A_STATUS, 16'h0001);
    cmd(16'h0000);
    wr(`RSS_A_POLICY, 16'h0001);
    measured_value <= 16'h2000;
    cmd(16'h0001);
    rd(`RSS_A_STATUS, 16'h0001);
    cmd(16'h0000);
    wr(`RSS_A_MODE, 16'h0008);
    measured_value <= 16'h0C00;
    pw(1'b0);
    rd(`RSS_A_STATUS, 16'h0001);
    rd(`RSS_A_SETPOINT, 16'h0C00);
    tk(4);
    cmd(16'h0000);
    pw(1'b1);
    rd(`RSS_A_STATUS, 16'h0001);
    $display("test power done");
    cmd(16'h0000);
    wr(`RSS_A_CEIL, 16'h001F);
    wr(`RSS_A_FLOOR, 16'h001D);
    key(1'b1, 32);
    rd(`RSS_A_PATSEL, 16'h001F);
    key(1'b0, 4);
    rd(`RSS_A_PATSEL, 16'h001D);
    $display("test keys done");
    repeat (4) @(posedge clk_sys);
    stop_test();
  end
  // Watchdog far past the expected run
  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end
endmodule
bind rss_sequencer rss_seq_asserts u_chk (.*);
